// File: hw/eoc_pkg.sv
// eoc_pkg: constants and carrier types for the external oscillator control register
// assumes an 8-bit special-function-register bus clocked by the system clock
package eoc_pkg;

  localparam logic [7:0] EOC_REG_ADDR = 8'hB5;
  localparam logic [7:0] EOC_REG_RESET = 8'h00;
  localparam int EOC_VALID_BIT = 7;
  localparam int EOC_MODE_HI = 6;
  localparam int EOC_MODE_LO = 4;
  localparam int EOC_UNUSED_BIT = 3;
  localparam int EOC_FREQ_HI = 2;
  localparam int EOC_FREQ_LO = 0;
  localparam logic [2:0] EOC_MODE_RESET = 3'h0;
  localparam logic [2:0] EOC_FREQ_RESET = 3'h0;

  // mode codes of ext_osc_mode_select
  localparam logic [2:0] EOC_MODE_CMOS = 3'h2;
  localparam logic [2:0] EOC_MODE_CMOS_DIV2 = 3'h3;
  localparam logic [2:0] EOC_MODE_RC = 3'h4;
  localparam logic [2:0] EOC_MODE_CAP = 3'h5;
  localparam logic [2:0] EOC_MODE_XTAL = 3'h6;
  localparam logic [2:0] EOC_MODE_XTAL_DIV2 = 3'h7;

  typedef enum logic [5:0] {
    EOC_OFF = 6'h01,
    EOC_CMOS = 6'h02,
    EOC_RC = 6'h04,
    EOC_CAP = 6'h08,
    EOC_XTAL = 6'h10,
    EOC_RSVD = 6'h20
  } eoc_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eoc_bus_s;

  // drive controls handed to the analog oscillator
  typedef struct packed {
    logic enable;
    logic cmos_sel;
    logic rc_sel;
    logic cap_sel;
    logic xtal_sel;
    logic div2;
    logic [2:0] freq;
  } eoc_drive_s;

endpackage : eoc_pkg

// File: hw/eoc_sync.sv
// eoc_sync: two-flop synchroniser for a level from outside the clock domain
// assumes the level changes slowly compared with clk_in
`timescale 1ns/1ns
module eoc_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic sync;
  } eoc_sync_s;

  eoc_sync_s st;
  eoc_sync_s next_st;

  always_comb begin
    next_st.meta = async_in;
    next_st.sync = st.meta;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.sync;
endmodule : eoc_sync

// File: hw/eoc_ctrl.sv
// eoc_ctrl: external oscillator control register and mode decode
// assumes an 8-bit register port with one-cycle read and write strobes and
// a stability level from the analog amplitude detector on another clock
`timescale 1ns/1ns

// How it works
// - bit 7 reads crystal-valid: 1 when crystal stable, only in mode 11x.
// - mode 00x keeps the external oscillator circuit disabled.
// - mode 010 takes a digital clock; 011 adds divide by two.
// - mode 100 runs RC oscillator; mode 101 runs capacitor oscillator.
// - mode 110 runs crystal oscillator; 111 adds divide by two.
// - bit 3 always reads zero; writes to it are ignored.
// - bits 2:0 select frequency drive range for crystal and RC modes.
// - in capacitor mode bits 2:0 select the K factor.
module eoc_ctrl import eoc_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire eoc_bus_s bus_in,
  input wire logic xtal_stable_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output eoc_drive_s drive_out,
  output eoc_mode_e mode_out
);
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] freq;
    logic [7:0] rdata;
    logic rvalid;
    eoc_drive_s drive;
    eoc_mode_e mode_state;
  } eoc_state_s;

  eoc_state_s st;
  eoc_state_s next_st;
  logic stable_sync;
  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic valid_flag;
  logic [2:0] new_mode;
  logic [2:0] new_freq;

  // every code is decoded on its own so at most one select line is set per mode, none in mode 00x
  function automatic eoc_drive_s drive_for_code(input logic [2:0] code, input logic [2:0] freq);
    eoc_drive_s drv;
    drv = '0;
    drv.freq = freq;
    case (code)
      3'h0: begin
        drv.enable = 1'b0;
        drv.cmos_sel = 1'b0;
        drv.rc_sel = 1'b0;
        drv.cap_sel = 1'b0;
        drv.xtal_sel = 1'b0;
        drv.div2 = 1'b0;
      end
      3'h1: begin
        drv.enable = 1'b0;
        drv.cmos_sel = 1'b0;
        drv.rc_sel = 1'b0;
        drv.cap_sel = 1'b0;
        drv.xtal_sel = 1'b0;
        drv.div2 = 1'b0;
      end
      EOC_MODE_CMOS: begin
        drv.enable = 1'b1;
        drv.cmos_sel = 1'b1;
        drv.rc_sel = 1'b0;
        drv.cap_sel = 1'b0;
        drv.xtal_sel = 1'b0;
        drv.div2 = 1'b0;
      end
      EOC_MODE_CMOS_DIV2: begin
        drv.enable = 1'b1;
        drv.cmos_sel = 1'b1;
        drv.rc_sel = 1'b0;
        drv.cap_sel = 1'b0;
        drv.xtal_sel = 1'b0;
        drv.div2 = 1'b1;
      end
      EOC_MODE_RC: begin
        drv.enable = 1'b1;
        drv.cmos_sel = 1'b0;
        drv.rc_sel = 1'b1;
        drv.cap_sel = 1'b0;
        drv.xtal_sel = 1'b0;
        drv.div2 = 1'b0;
      end
      EOC_MODE_CAP: begin
        drv.enable = 1'b1;
        drv.cmos_sel = 1'b0;
        drv.rc_sel = 1'b0;
        drv.cap_sel = 1'b1;
        drv.xtal_sel = 1'b0;
        drv.div2 = 1'b0;
      end
      EOC_MODE_XTAL: begin
        drv.enable = 1'b1;
        drv.cmos_sel = 1'b0;
        drv.rc_sel = 1'b0;
        drv.cap_sel = 1'b0;
        drv.xtal_sel = 1'b1;
        drv.div2 = 1'b0;
      end
      EOC_MODE_XTAL_DIV2: begin
        drv.enable = 1'b1;
        drv.cmos_sel = 1'b0;
        drv.rc_sel = 1'b0;
        drv.cap_sel = 1'b0;
        drv.xtal_sel = 1'b1;
        drv.div2 = 1'b1;
      end
      default: begin
        drv = '0;
      end
    endcase
    return drv;
  endfunction : drive_for_code

  function automatic eoc_mode_e state_for_code(input logic [2:0] code);
    eoc_mode_e dec;
    dec = EOC_RSVD;
    case (code)
      3'h0: begin
        dec = EOC_OFF;
      end
      3'h1: begin
        dec = EOC_OFF;
      end
      EOC_MODE_CMOS: begin
        dec = EOC_CMOS;
      end
      EOC_MODE_CMOS_DIV2: begin
        dec = EOC_CMOS;
      end
      EOC_MODE_RC: begin
        dec = EOC_RC;
      end
      EOC_MODE_CAP: begin
        dec = EOC_CAP;
      end
      EOC_MODE_XTAL: begin
        dec = EOC_XTAL;
      end
      EOC_MODE_XTAL_DIV2: begin
        dec = EOC_XTAL;
      end
      default: begin
        dec = EOC_RSVD;
      end
    endcase
    return dec;
  endfunction : state_for_code

  // the register image as firmware reads it; bit 3 has no storage behind it
  function automatic logic [7:0] reg_image(input logic [2:0] mode, input logic [2:0] freq, input logic valid);
    logic [7:0] img;
    img = EOC_REG_RESET;
    img[EOC_VALID_BIT] = valid;
    img[EOC_MODE_HI:EOC_MODE_LO] = mode;
    img[EOC_UNUSED_BIT] = 1'b0;
    img[EOC_FREQ_HI:EOC_FREQ_LO] = freq;
    return img;
  endfunction : reg_image

  // the detector runs off the oscillator, so its level is synchronised first
  eoc_sync u_stable_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(xtal_stable_in),
    .sync_out(stable_sync)
  );

  assign hit = (bus_in.addr == EOC_REG_ADDR);
  assign wr_hit = bus_in.wr && hit;
  assign rd_hit = bus_in.rd && hit;
  // flag is masked outside crystal modes so a stale detector level never reads 1
  assign valid_flag = stable_sync && (st.mode[2:1] == EOC_MODE_XTAL[2:1]);

  always_comb begin
    next_st = st;
    new_mode = st.mode;
    new_freq = st.freq;
    if (wr_hit) begin
      // bit 3 and bit 7 of the write data are dropped
      new_mode = bus_in.wdata[EOC_MODE_HI:EOC_MODE_LO];
      new_freq = bus_in.wdata[EOC_FREQ_HI:EOC_FREQ_LO];
    end
    next_st.mode = new_mode;
    next_st.freq = new_freq;

    // a read in the same cycle as a write returns the old contents
    next_st.rvalid = rd_hit;
    next_st.rdata = 8'h00;
    if (rd_hit) begin
      next_st.rdata = reg_image(st.mode, st.freq, valid_flag);
    end

    // decode follows the new code so the analog side sees it one cycle after the write
    next_st.drive = drive_for_code(new_mode, new_freq);
    next_st.mode_state = state_for_code(new_mode);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st.mode <= EOC_MODE_RESET;
      st.freq <= EOC_FREQ_RESET;
      st.rdata <= EOC_REG_RESET;
      st.rvalid <= 1'b0;
      st.drive <= '0;
      st.mode_state <= EOC_OFF;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out = st.rdata;
  assign rvalid_out = st.rvalid;
  assign drive_out = st.drive;
  assign mode_out = st.mode_state;
endmodule : eoc_ctrl

// File: bench/eoc_xtal_model.sv
// eoc_xtal_model: crystal whose amplitude settles START cycles after enable
// assumes drive_in comes straight from eoc_ctrl
`timescale 1ns/1ns
module eoc_xtal_model import eoc_pkg::*; #(parameter int START = 200) (
  input wire logic clk_in,
  input wire eoc_drive_s drive_in,
  output logic stable_out
);
  int n = 0;
  // leaving the crystal modes restarts the settling; a switch between 110 and 111 or a new freq does not
  always @(posedge clk_in) n <= drive_in.enable && drive_in.xtal_sel ? (n < START ? n + 1 : n) : 0;
  assign stable_out = n == START;
endmodule : eoc_xtal_model

// File: bench/eoc_ctrl_properties.sv
// eoc_ctrl_properties: port checks of the oscillator control register
// assumes it is bound to eoc_ctrl and sees its ports only
`timescale 1ns/1ns
module eoc_ctrl_properties import eoc_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire eoc_bus_s bus_in,
  input wire logic xtal_stable_in,
  input wire logic [7:0] rdata_out,
  input wire logic rvalid_out,
  input wire eoc_drive_s drive_out,
  input wire eoc_mode_e mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic w;
  logic r;
  logic [2:0] m;
  eoc_drive_s d;
  assign w = bus_in.wr && bus_in.addr == EOC_REG_ADDR;
  assign r = bus_in.rd && bus_in.addr == EOC_REG_ADDR;
  assign m = bus_in.wdata[6:4];
  assign d = drive_out;
  AST_OFF: assert property (w && m < 2 |=> !d.enable && mode_out == EOC_OFF) else $error("off mode");
  AST_CMOS: assert property (w && m[2:1] == 1 |=> d.cmos_sel && d.div2 == $past(m[0])) else $error("cmos");
  AST_CAP: assert property (w && m == 5 |=> d.cap_sel && mode_out == EOC_CAP) else $error("cap");
  AST_RC: assert property (w && m == 4 |=> d.rc_sel && mode_out == EOC_RC) else $error("rc");
  AST_XTAL: assert property (w && m > 5 |=> d.xtal_sel && d.div2 == $past(m[0])) else $error("xtal");
  AST_FREQ: assert property (w |=> d.freq == $past(bus_in.wdata[2:0])) else $error("freq");
  AST_BIT3: assert property (rvalid_out |-> !rdata_out[3]) else $error("bit 3");
  AST_READ: assert property (r |=> rvalid_out && rdata_out[2:0] == $past(d.freq)) else $error("read");
  AST_MASK: assert property (rvalid_out && !$past(d.xtal_sel) |-> !rdata_out[7]) else $error("mask");
  AST_VALID: assert property (rvalid_out && $past(d.xtal_sel) && $past(xtal_stable_in, 3) |->
    rdata_out[7]) else $error("valid");
  AST_NOVALID: assert property (rvalid_out && !$past(xtal_stable_in, 3) |-> !rdata_out[7]) else $error("not valid");
  cover property (rvalid_out && rdata_out[7]);
  cover property (w && m == 3);
  cover property (w && bus_in.wdata[3]);
endmodule : eoc_ctrl_properties
bind eoc_ctrl eoc_ctrl_properties chk_u (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in),
  .xtal_stable_in(xtal_stable_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .drive_out(drive_out),
  .mode_out(mode_out));

// File: bench/tb.sv
// tb: random and corner register traffic against eoc_ctrl with a crystal model
// assumes the package, the design and the checker are compiled first
`timescale 1ns/1ns
module tb import eoc_pkg::*; ;
  logic clk_in = 0;
  logic rst_in = 1;
  logic stable;
  logic rvalid;
  logic [7:0] rdata;
  logic [7:0] v;
  eoc_bus_s bus = '0;
  eoc_drive_s drive;
  eoc_mode_e mode;
  int num_errors = 0;
  int check_count = 0;
  int seed = 32'h6BDCB596;
  always #50 clk_in = ~clk_in;
  eoc_xtal_model #(.START(200)) xtal_u (.clk_in(clk_in), .drive_in(drive), .stable_out(stable));
  eoc_ctrl dut_u (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus), .xtal_stable_in(stable),
    .rdata_out(rdata), .rvalid_out(rvalid), .drive_out(drive), .mode_out(mode));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_in);
    bus <= '{w, !w, a, x};
    @(posedge clk_in);
    bus <= '0;
    #1;
  endtask : acc
  function automatic eoc_drive_s exp_drv(input logic [7:0] x);
    return '{x[6:5] != 0, x[6:5] == 1, x[6:4] == 4, x[6:4] == 5, x[6:5] == 3, x[5] & x[4], x[2:0]};
  endfunction : exp_drv
  function automatic eoc_mode_e exp_mode(input logic [7:0] x);
    case (x[6:4])
      3'h0, 3'h1: return EOC_OFF;
      3'h2, 3'h3: return EOC_CMOS;
      3'h4: return EOC_RC;
      3'h5: return EOC_CAP;
      default: return EOC_XTAL;
    endcase
  endfunction : exp_mode
  task automatic wr(input logic [7:0] x);
    acc(1'b1, EOC_REG_ADDR, x);
    chk(16'(drive), 16'(exp_drv(x)));
    chk(16'(mode), 16'(exp_mode(x)));
  endtask : wr
  task automatic rd(input logic [7:0] e);
    acc(1'b0, EOC_REG_ADDR, 8'h00);
    chk(16'({rvalid, rdata}), 16'({1'b1, e}));
  endtask : rd
  task print_verdict;
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 0;
    rd(EOC_REG_RESET);
    // first eight pass every mode code, odd ones with bits 7 and 3 set
    for (int i = 0; i < 40; i++) begin
      v = i < 8 ? {i[0], i[2:0], i[0], 3'h7 - i[2:0]} : 8'($random(seed));
      wr(v);
      rd({1'b0, v[6:4], 1'b0, v[2:0]});
    end
    wr(8'h07);
    wr(8'h67);
    rd(8'h67);
    repeat (210) @(posedge clk_in);
    rd(8'hE7);
    wr(8'hE0);
    rd(8'hE0);
    // reset again while the crystal reads valid
    @(posedge clk_in);
    rst_in <= 1;
    repeat (4) @(posedge clk_in);
    rst_in <= 0;
    rd(EOC_REG_RESET);
    chk(16'(drive), 16'h0000);
    chk(16'(mode), 16'(EOC_OFF));
    acc(1'b0, 8'hB4, 8'h00);
    chk(16'({rvalid, rdata}), 16'h0000);
    wr(8'h40);
    rd(8'h40);
    print_verdict();
  end
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule : tb
